/* bench/fpec_flash_model.sv */
// Behavioural flash array on the far side of the controller
`timescale 1ns/10ps
`default_nettype none
module fpec_flash_model (
  input  wire logic        pclk,
  input  wire logic [15:0] flash_addr,
  input  wire logic [7:0]  flash_wdata,
  input  wire logic        flash_prog,
  input  wire logic        flash_page_erase,
  input  wire logic        flash_mass_erase
);
  logic [7:0] mem [0:4095];
  int         n_ops;
  logic [2:0] ops_q;

  initial begin
    n_ops = 0;
    ops_q = 3'h0;
    for (int i = 0; i < 4096; i++) begin
      mem[i] = i[7:0];
    end
  end

  always @(posedge pclk) begin
    if (flash_prog && !ops_q[0]) begin
      mem[flash_addr[11:0]] = mem[flash_addr[11:0]] & flash_wdata;
      n_ops++;
    end
    if (flash_page_erase && !ops_q[1]) begin
      for (int i = 0; i < 512; i++) begin
        mem[{flash_addr[11:9], i[8:0]}] = 8'hff;
      end
      n_ops++;
    end
    if (flash_mass_erase && !ops_q[2]) begin
      for (int i = 0; i < 4096; i++) begin
        mem[i] = 8'hff;
      end
      n_ops++;
    end
    ops_q = {flash_mass_erase, flash_page_erase, flash_prog};
  end
endmodule : fpec_flash_model
`default_nettype wire

/* bench/testbench.sv */
// Register-level testbench for the flash program/erase controller
`timescale 1ns/10ps
`default_nettype none
module testbench;
  import fpec_pkg::*;
  logic        pclk, presetn, psel, penable, pwrite, pready, pslverr;
  logic        debug_access, write_protect_opt, xtal_en_in_reset, rerr;
  logic        flash_prog, flash_page_erase, flash_mass_erase;
  logic [7:0]  paddr, flash_wdata;
  logic [15:0] flash_addr;
  logic [31:0] pwdata, prdata, rdat;
  int          n_fail = 0;
  int          comparisons = 0;

  fpec_ctrl #(.PERASE_CYCLES(CNT_W'(20)), .MERASE_CYCLES(CNT_W'(40))) DUT (
    .pclk(pclk), .presetn(presetn), .psel(psel), .penable(penable), .pwrite(pwrite),
    .paddr(paddr), .pwdata(pwdata), .pready(pready), .prdata(prdata), .pslverr(pslverr),
    .debug_access(debug_access), .write_protect_opt(write_protect_opt),
    .flash_addr(flash_addr), .flash_wdata(flash_wdata), .flash_prog(flash_prog),
    .flash_page_erase(flash_page_erase), .flash_mass_erase(flash_mass_erase),
    .xtal_en_in_reset(xtal_en_in_reset)
  );

  fpec_flash_model mdl (
    .pclk(pclk), .flash_addr(flash_addr), .flash_wdata(flash_wdata),
    .flash_prog(flash_prog), .flash_page_erase(flash_page_erase),
    .flash_mass_erase(flash_mass_erase)
  );

  initial begin
    pclk = 1'b0;
    forever #4 pclk = ~pclk;
  end

  task automatic report_and_stop();
    $display("comparisons %0d mismatches %0d", comparisons, n_fail);
    if (n_fail == 0 && comparisons > 0) begin
      $display("== PASSED ==");
    end else begin
      $display("== FAILED ==");
    end
    $finish;
  endtask : report_and_stop

  task automatic chk(input logic [31:0] seen, input logic [31:0] exp);
    comparisons++;
    if (seen !== exp) begin
      n_fail++;
      $display("CHECK FAILED at %0t: got %h expected %h", $time, seen, exp);
    end
  endtask : chk

  task automatic apb(input logic wr, input logic [7:0] a, input logic [31:0] d);
    int i;
    @(posedge pclk);
    psel   <= 1'b1;
    pwrite <= wr;
    paddr  <= a;
    pwdata <= d;
    @(posedge pclk);
    penable <= 1'b1;
    for (i = 0; i < 50; i++) begin
      @(posedge pclk);
      if (pready === 1'b1) break;
    end
    chk(32'(i < 50), 32'h1);
    rdat = prdata;
    rerr = pslverr;
    psel    <= 1'b0;
    penable <= 1'b0;
  endtask : apb

  task automatic wr(input logic [7:0] a, input logic [31:0] d);
    apb(1'b1, a, d);
  endtask : wr

  task automatic rd(input logic [7:0] a, input logic [31:0] exp, input logic [31:0] m);
    apb(1'b0, a, 32'h0);
    chk(rdat & m, exp);
  endtask : rd

  task automatic wait_op();
    int i;
    repeat (2) @(posedge pclk);
    for (i = 0; i < 3000 && (flash_prog | flash_page_erase | flash_mass_erase) !== 1'b0; i++) begin
      @(posedge pclk);
    end
    chk(32'(i < 3000), 32'h1);
  endtask : wait_op

  // Relock first, then the full unlock pair
  task automatic unlock(input logic [7:0] p);
    wr(A_CMD, 32'h0);
    wr(A_PSEL, 32'(p));
    wr(A_CMD, 32'(CMD_KEY1));
    wr(A_CMD, 32'(CMD_KEY2));
    if (!debug_access) wr(A_PSEL, 32'(p));
    wr(A_STAT, 32'h4);
    rd(A_STAT, 32'h1, 32'h1);
  endtask : unlock

  initial begin
    repeat (40000) @(posedge pclk);
    n_fail++;
    report_and_stop();
  end

  initial begin
    presetn = 1'b0;
    psel = 1'b0;
    penable = 1'b0;
    pwrite = 1'b0;
    paddr = 8'h00;
    pwdata = 32'h0;
    debug_access = 1'b0;
    write_protect_opt = 1'b0;
    repeat (12) @(posedge pclk);
    presetn <= 1'b1;
    wr(A_OPT, 32'hef);
    rd(A_OPT, 32'hef, 32'hff);
    chk(32'(xtal_en_in_reset), 32'h1);
    wr(A_OPT, 32'hff);
    rd(A_OPT, 32'hff, 32'hff);
    chk(32'(xtal_en_in_reset), 32'h0);
    apb(1'b0, 8'h40, 32'h0);
    chk(32'(rerr), 32'h1);
    unlock(8'h01);
    wr(A_CMD, 32'(CMD_PERASE));
    wait_op();
    chk(32'(mdl.n_ops), 32'h1);
    chk(32'(mdl.mem[12'h200]), 32'hff);
    chk(32'(mdl.mem[12'h3ff]), 32'hff);
    chk(32'(mdl.mem[12'h1fe]), 32'hfe);
    chk(32'(mdl.mem[12'h400]), 32'h00);
    wr(A_ADDR, 32'h205);
    wr(A_DATA, 32'h5a);
    rd(A_STAT, 32'h2, 32'h2);
    wait_op();
    chk(32'(mdl.mem[12'h205]), 32'h5a);
    wr(A_ADDR, 32'h405);
    wr(A_DATA, 32'h00);
    rd(A_STAT, 32'h4, 32'h4);
    chk(32'(mdl.mem[12'h405]), 32'h05);
    wr(A_STAT, 32'h4);
    wr(A_PSEL, 32'h2);
    rd(A_PSEL, 32'h1, 32'hff);
    rd(A_STAT, 32'h4, 32'h5);
    unlock(8'h01);
    wr(A_CMD, 32'(CMD_MERASE));
    rd(A_STAT, 32'h4, 32'h7);
    chk(32'(mdl.n_ops), 32'h2);
    wr(A_CMD, 32'h0);
    wr(A_PSEL, 32'h1);
    wr(A_CMD, 32'(CMD_KEY1));
    wr(A_CMD, 32'h11);
    wr(A_CMD, 32'(CMD_KEY2));
    wr(A_PSEL, 32'h1);
    rd(A_STAT, 32'h0, 32'h1);
    wr(A_PROT, 32'h2);
    wr(A_PROT, 32'h0);
    rd(A_PROT, 32'h2, 32'hff);
    unlock(8'h01);
    wr(A_ADDR, 32'h210);
    wr(A_DATA, 32'h00);
    rd(A_STAT, 32'h4, 32'h4);
    write_protect_opt <= 1'b1;
    unlock(8'h03);
    wr(A_ADDR, 32'h610);
    wr(A_DATA, 32'h00);
    rd(A_STAT, 32'h4, 32'h4);
    chk(32'(mdl.mem[12'h610]), 32'h10);
    debug_access <= 1'b1;
    wr(A_PROT, 32'h0);
    rd(A_PROT, 32'h0, 32'hff);
    wr(A_PROT, 32'h2);
    unlock(8'h01);
    wr(A_PSEL, 32'h5);
    rd(A_PSEL, 32'h5, 32'hff);
    rd(A_STAT, 32'h1, 32'h5);
    wr(A_ADDR, 32'h234);
    wr(A_DATA, 32'hc3);
    wait_op();
    chk(32'(mdl.mem[12'h234]), 32'hc3);
    wr(A_ADDR, 32'hfe00);
    wr(A_DATA, 32'h00);
    rd(A_STAT, 32'h4, 32'h4);
    chk(32'(mdl.n_ops), 32'h3);
    wr(A_STAT, 32'h4);
    wr(A_CMD, 32'(CMD_MERASE));
    wait_op();
    chk(32'(mdl.mem[12'h800]), 32'hff);
    chk(32'(mdl.mem[12'h234]), 32'hff);
    presetn <= 1'b0;
    repeat (12) @(posedge pclk);
    presetn <= 1'b1;
    rd(A_OPT, 32'hff, 32'hff);
    chk(32'(xtal_en_in_reset), 32'h0);
    rd(A_STAT, 32'h0, 32'h7);
    report_and_stop();
  end
endmodule : testbench
`default_nettype wire

/* src/fpec_ctrl.sv */
// Flash program/erase controller with APB register slave
`timescale 1ns/10ps
`default_nettype none
module fpec_ctrl
  import fpec_pkg::*;
#(
  parameter logic [CNT_W-1:0] PERASE_CYCLES = CNT_W'(PERASE_CYC),
  parameter logic [CNT_W-1:0] MERASE_CYCLES = CNT_W'(MERASE_CYC)
) (
  input  wire logic        pclk,
  input  wire logic        presetn,
  input  wire logic        psel,
  input  wire logic        penable,
  input  wire logic        pwrite,
  input  wire logic [7:0]  paddr,
  input  wire logic [31:0] pwdata,
  output logic             pready,
  output logic [31:0]      prdata,
  output logic             pslverr,
  input  wire logic        debug_access,
  input  wire logic        write_protect_opt,
  output logic [15:0]      flash_addr,
  output logic [7:0]       flash_wdata,
  output logic             flash_prog,
  output logic             flash_page_erase,
  output logic             flash_mass_erase,
  output logic             xtal_en_in_reset
);
  typedef struct packed {
    fpec_state_t st;
    logic [7:0]  sel;
    logic [7:0]  prot;
    logic [15:0] addr;
    logic [7:0]  data;
    logic        refused;
    logic        pready;
    logic        pslverr;
    logic [31:0] prdata;
    logic [15:0] fl_addr;
    logic [7:0]  fl_data;
    logic        fl_prog;
    logic        fl_perase;
    logic        fl_merase;
    logic        xtal_en;
  } fpec_regs_t;
  fpec_regs_t r_q, r_d;

  // Option byte lives with the array, so no reset
  logic [7:0]       opt_q;
  logic             wr_en;
  logic             rd_setup;
  logic             op_done;
  logic             tmr_start;
  logic [CNT_W-1:0] tmr_cycles;

  function automatic logic [2:0] sector_of(input logic [15:0] a);
    return a[PAGE_LSB+2:PAGE_LSB];
  endfunction

  function automatic logic [6:0] page_of(input logic [15:0] a);
    return a[15:PAGE_LSB];
  endfunction

  function automatic logic in_pmem(input logic [15:0] a);
    return a[15:12] == PMEM_TOP;
  endfunction

  assign wr_en    = psel & penable & r_q.pready & pwrite;
  assign rd_setup = psel & ~penable & ~r_q.pready;

  logic prog_ok;
  logic perase_ok;
  logic [15:0] sel_base;
  assign sel_base = {r_q.sel[6:0], 9'h000};
  assign prog_ok = in_pmem(r_q.addr) && page_of(r_q.addr) != INFO_PAGE
                   && (debug_access || (!write_protect_opt
                   && !r_q.prot[sector_of(r_q.addr)]
                   && page_of(r_q.addr) == r_q.sel[6:0]));
  assign perase_ok = in_pmem(sel_base) && r_q.sel[6:0] != INFO_PAGE
                     && (debug_access || (!write_protect_opt
                     && !r_q.prot[sector_of(sel_base)]));

  fpec_timer u_timer (
    .pclk    (pclk),
    .presetn (presetn),
    .start   (tmr_start),
    .cycles  (tmr_cycles),
    .done    (op_done)
  );

  always_ff @(posedge pclk) begin
    if (wr_en && paddr == A_OPT) begin
      opt_q <= pwdata[7:0];
    end
  end

  always_comb begin
    r_d        = r_q;
    tmr_start  = 1'b0;
    tmr_cycles = CNT_W'(PROG_CYC);
    r_d.pready = rd_setup;
    r_d.pslverr = 1'b0;
    // crystal held off when bit set
    // only an enable, no clock select
    r_d.xtal_en = ~opt_q[OPT_XTAL_OFF];
    if (rd_setup) begin
      r_d.prdata  = '0;
      case (paddr)
        A_CMD:  r_d.prdata = '0;
        A_OPT:  r_d.prdata = {24'h0, opt_q};
        A_STAT: begin
          r_d.prdata[ST_UNLOCKED] = r_q.st == FPEC_UNLOCKED;
          r_d.prdata[ST_BUSY]     = r_q.st == FPEC_BUSY;
          r_d.prdata[ST_REFUSED]  = r_q.refused;
          r_d.prdata[ST_DEBUG]    = debug_access;
        end
        A_PSEL: r_d.prdata = {24'h0, r_q.sel};
        A_PROT: r_d.prdata = {24'h0, r_q.prot};
        A_ADDR: r_d.prdata = {16'h0, r_q.addr};
        A_DATA: r_d.prdata = {24'h0, r_q.data};
        default: r_d.pslverr = 1'b1;
      endcase
    end
    if (wr_en) begin
      case (paddr)
        A_STAT: begin
          if (pwdata[ST_REFUSED]) begin
            r_d.refused = 1'b0;
          end
        end
        A_PROT: begin
          if (debug_access) begin
            r_d.prot = pwdata[7:0];
          end else begin
            r_d.prot = r_q.prot | pwdata[7:0];
          end
        end
        A_ADDR: r_d.addr = pwdata[15:0];
        A_PSEL: begin
          case (r_q.st)
            FPEC_SELWAIT: begin
              if (pwdata[7:0] == r_q.sel) begin
                r_d.st = FPEC_UNLOCKED;
              end else begin
                r_d.st = FPEC_LOCKED;
              end
            end
            FPEC_UNLOCKED: begin
              if (debug_access) begin
                r_d.sel = pwdata[7:0];
              end else begin
                r_d.st      = FPEC_LOCKED;
                r_d.refused = 1'b1;
              end
            end
            FPEC_BUSY: r_d.refused = 1'b1;
            default: r_d.sel = pwdata[7:0];
          endcase
        end
        A_DATA: begin
          r_d.data = pwdata[7:0];
          if (r_q.st == FPEC_UNLOCKED && prog_ok) begin
            r_d.st      = FPEC_BUSY;
            r_d.fl_addr = r_q.addr;
            r_d.fl_data = pwdata[7:0];
            r_d.fl_prog = 1'b1;
            tmr_start   = 1'b1;
          end else begin
            r_d.refused = 1'b1;
          end
        end
        A_CMD: begin
          case (r_q.st)
            FPEC_LOCKED: begin
              if (pwdata[7:0] == CMD_KEY1) begin
                r_d.st = FPEC_KEY1;
              end
            end
            FPEC_KEY1: begin
              if (pwdata[7:0] != CMD_KEY2) begin
                r_d.st = FPEC_LOCKED;
              end else if (debug_access) begin
                r_d.st = FPEC_UNLOCKED;
              end else begin
                r_d.st = FPEC_SELWAIT;
              end
            end
            FPEC_UNLOCKED: begin
              r_d.st = FPEC_LOCKED;
              if (pwdata[7:0] == CMD_PERASE && perase_ok) begin
                r_d.st        = FPEC_BUSY;
                r_d.fl_addr   = sel_base;
                r_d.fl_perase = 1'b1;
                tmr_start     = 1'b1;
                tmr_cycles    = PERASE_CYCLES;
              end else if (pwdata[7:0] == CMD_MERASE && debug_access) begin
                r_d.st        = FPEC_BUSY;
                r_d.fl_addr   = '0;
                r_d.fl_merase = 1'b1;
                tmr_start     = 1'b1;
                tmr_cycles    = MERASE_CYCLES;
              end else begin
                r_d.refused = 1'b1;
              end
            end
            FPEC_BUSY: r_d.refused = 1'b1;
            default: r_d.st = FPEC_LOCKED;
          endcase
        end
        default: ;
      endcase
    end
    if (op_done && r_q.st == FPEC_BUSY) begin
      r_d.st        = FPEC_UNLOCKED;
      r_d.fl_prog   = 1'b0;
      r_d.fl_perase = 1'b0;
      r_d.fl_merase = 1'b0;
    end
  end

  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      r_q         <= '0;
      r_q.st      <= FPEC_LOCKED;
      r_q.sel     <= PSEL_RST;
      r_q.prot    <= PROT_RST;
      r_q.xtal_en <= 1'b0;
    end else begin
      r_q <= r_d;
    end
  end

  assign pready           = r_q.pready;
  assign prdata           = r_q.prdata;
  assign pslverr          = r_q.pslverr;
  assign flash_addr       = r_q.fl_addr;
  assign flash_wdata      = r_q.fl_data;
  assign flash_prog       = r_q.fl_prog;
  assign flash_page_erase = r_q.fl_perase;
  assign flash_mass_erase = r_q.fl_merase;
  assign xtal_en_in_reset = r_q.xtal_en;

  default clocking cb @(posedge pclk);
  endclocking
  default disable iff (!presetn);

  a_info_no_prog: assert property (
    $rose(flash_prog) |-> flash_addr[15:PAGE_LSB] != INFO_PAGE)
    else $error("program started in info area");
  a_prog_timing: assert property (
    $rose(flash_prog) |-> flash_prog [*8])
    else $error("program pulse too short");
  a_prot_sector: assert property (
    $rose(flash_prog) && !debug_access |-> !r_q.prot[flash_addr[11:9]])
    else $error("program into protected sector");
  a_wp_honoured: assert property (
    wr_en && paddr == A_DATA && write_protect_opt && !debug_access
    |=> !$rose(flash_prog))
    else $error("write protect bypassed");
  a_prot_setonly: assert property (
    !debug_access && wr_en && paddr == A_PROT |=> (r_q.prot & $past(r_q.prot))
    == $past(r_q.prot))
    else $error("protect bit cleared outside debug");
  a_unlock_pair: assert property (
    r_q.st == FPEC_LOCKED |=> r_q.st inside {FPEC_LOCKED, FPEC_KEY1})
    else $error("unlocked without key pair");
  a_perase_page: assert property (
    $rose(flash_page_erase) |-> flash_addr == {r_q.sel[6:0], 9'h000})
    else $error("page erase on wrong page");
  a_merase_debug: assert property (
    $rose(flash_mass_erase) |-> $past(debug_access))
    else $error("mass erase outside debug");
  a_relock_bad: assert property (
    r_q.st == FPEC_KEY1 && wr_en && paddr == A_CMD && pwdata[7:0] != CMD_KEY2
    |=> r_q.st == FPEC_LOCKED)
    else $error("broken sequence did not relock");
  a_single_page: assert property (
    r_q.st == FPEC_UNLOCKED && !debug_access && wr_en && paddr == A_PSEL
    |=> r_q.st == FPEC_LOCKED && r_q.sel == $past(r_q.sel))
    else $error("second page opened");

  a_merase_base: assert property (
    $rose(flash_mass_erase) |-> flash_addr == 16'h0000)
    else $error("mass erase address not zero");
  a_wp_erase: assert property (
    $rose(flash_page_erase) && !debug_access |-> !$past(write_protect_opt))
    else $error("page erase under write protect");
  a_debug_unlock: assert property (
    r_q.st == FPEC_KEY1 && wr_en && paddr == A_CMD && pwdata[7:0] == CMD_KEY2
    && debug_access |=> r_q.st == FPEC_UNLOCKED)
    else $error("debug unlock needed page select");
  a_key_selwait: assert property (
    r_q.st == FPEC_KEY1 && wr_en && paddr == A_CMD && pwdata[7:0] == CMD_KEY2
    && !debug_access |=> r_q.st == FPEC_SELWAIT)
    else $error("second key did not await page select");
  a_debug_reselect: assert property (
    r_q.st == FPEC_UNLOCKED && debug_access && wr_en && paddr == A_PSEL
    |=> r_q.st == FPEC_UNLOCKED && r_q.sel == $past(pwdata[7:0]))
    else $error("debug page reselect lost");
  a_prog_in_page: assert property (
    $rose(flash_prog) && !debug_access |-> flash_addr[15:PAGE_LSB] == r_q.sel[6:0])
    else $error("program outside open page");
  a_prog_data: assert property (
    $rose(flash_prog) |-> flash_wdata == $past(pwdata[7:0]))
    else $error("program byte differs from written data");
  a_xtal_follow: assert property (
    wr_en && paddr == A_OPT |=> ##1 xtal_en_in_reset != $past(pwdata[OPT_XTAL_OFF], 2))
    else $error("crystal enable does not follow option bit");
endmodule : fpec_ctrl
`default_nettype wire

/* src/fpec_pkg.sv */
// Constants for the flash program/erase controller
package fpec_pkg;
  // Clock and operation timing
  localparam int CLK_NS          = 8;
  localparam int PROG_TIME_NS    = 20000;
  localparam int PERASE_TIME_US  = 10000;
  localparam int MERASE_TIME_US  = 200000;
  localparam int PROG_CYC        = (PROG_TIME_NS + CLK_NS - 1) / CLK_NS;
  localparam int PERASE_CYC      = (PERASE_TIME_US * 1000 + CLK_NS - 1) / CLK_NS;
  localparam int MERASE_CYC      = (MERASE_TIME_US * 1000 + CLK_NS - 1) / CLK_NS;
  localparam int CNT_W           = 26;
  // Register map, APB byte addresses
  localparam logic [7:0] OPT_IDX      = 8'h01;
  localparam logic [7:0] A_CMD        = 8'h00;
  localparam logic [7:0] A_OPT        = {OPT_IDX[5:0], 2'b00};
  localparam logic [7:0] A_STAT       = 8'h08;
  localparam logic [7:0] A_PSEL       = 8'h0c;
  localparam logic [7:0] A_PROT       = 8'h10;
  localparam logic [7:0] A_ADDR       = 8'h14;
  localparam logic [7:0] A_DATA       = 8'h18;
  // Command codes
  localparam logic [7:0] CMD_KEY1     = 8'h73;
  localparam logic [7:0] CMD_KEY2     = 8'h8c;
  localparam logic [7:0] CMD_PERASE   = 8'h95;
  localparam logic [7:0] CMD_MERASE   = 8'h63;
  // Status fields
  localparam int ST_UNLOCKED = 0;
  localparam int ST_BUSY     = 1;
  localparam int ST_REFUSED  = 2;
  localparam int ST_DEBUG    = 3;
  // Option byte fields
  localparam int OPT_XTAL_OFF = 4;
  // Memory geometry: 512-byte pages and sectors
  localparam int PAGE_LSB     = 9;
  localparam logic [6:0] INFO_PAGE   = 7'h7f;
  localparam logic [3:0] PMEM_TOP    = 4'h0;
  // Reset values
  localparam logic [7:0] PSEL_RST = 8'h00;
  localparam logic [7:0] PROT_RST = 8'h00;
  typedef enum logic [2:0] {
    FPEC_LOCKED, FPEC_KEY1, FPEC_SELWAIT, FPEC_UNLOCKED, FPEC_BUSY
  } fpec_state_t;
endpackage : fpec_pkg

/* src/fpec_timer.sv */
// Operation duration counter
`timescale 1ns/10ps
`default_nettype none
module fpec_timer
  import fpec_pkg::*;
(
  input  wire logic             pclk,
  input  wire logic             presetn,
  input  wire logic             start,
  input  wire logic [CNT_W-1:0] cycles,
  output logic                  done
);
  typedef struct packed {
    logic [CNT_W-1:0] cnt;
    logic             run;
    logic             done;
  } fpec_tmr_t;
  fpec_tmr_t r_q, r_d;

  always_comb begin
    r_d      = r_q;
    r_d.done = 1'b0;
    if (start) begin
      r_d.cnt = cycles;
      r_d.run = 1'b1;
    end else if (r_q.run) begin
      if (r_q.cnt <= CNT_W'(1)) begin
        r_d.run  = 1'b0;
        r_d.done = 1'b1;
      end else begin
        r_d.cnt = r_q.cnt - CNT_W'(1);
      end
    end
  end

  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      r_q <= '0;
    end else begin
      r_q <= r_d;
    end
  end

  assign done = r_q.done;
endmodule : fpec_timer
`default_nettype wire
